//--- i2c_bus_sequence_control.sv
// two-wire bus sequence controller: master sequences and general call slave
//
// What this block does
// - general call received while enabled raises interrupt
// - general call disabled: address ignored, no interrupt
// - hold enable allows slave clock stretching with release
// - acknowledge sequence sends stored acknowledge value
// - ack request drives acknowledge sequence on lines
// - hardware clears ack request when sequence ends
// - receive request receives byte, cleared after bit eight
// - stop request drives stop, cleared at end
// - repeat start request drives it, cleared at end
// - start request drives start, cleared at end
`timescale 1ns/10ps
module i2c_bus_sequence_control
   import i2cseq_pkg::*;
#(
   parameter int HALF = i2cseq_pkg::HALF_CYC
) (
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST_N,
   input  wire logic [i2cseq_pkg::AW-1:0] ADDR,
   input  wire logic [i2cseq_pkg::DW-1:0] WDATA,
   input  wire logic                      WR,
   input  wire logic                      RD,
   output logic      [i2cseq_pkg::DW-1:0] RDATA,
   input  wire logic                      SCL_IN,
   output logic                           SCL_OUT,
   output logic                           SCL_OE,
   input  wire logic                      SDA_IN,
   output logic                           SDA_OUT,
   output logic                           SDA_OE,
   output logic                           IRQ
);
   import i2cseq_pkg::*;

   localparam int TW = $clog2(HALF + 1);

   typedef struct packed {
      logic [CW-1:0]  ctrl;
      logic [NEV-1:0] flag;
      logic [NEV-1:0] mask;
      logic [7:0]     rxd;
      logic [DW-1:0]  rdata;
      logic           irq;
      mseq_t          ms;
      logic [1:0]     ph;
      logic [TW-1:0]  tmr;
      logic [2:0]     mbit;
      logic [7:0]     msh;
      logic           m_scl_lo;
      logic           m_sda_lo;
      sslv_t          ss;
      logic [3:0]     sbit;
      logic [7:0]     ssh;
      logic           s_gc;
      logic           s_scl_lo;
      logic           s_sda_lo;
      logic           scl_oe;
      logic           sda_oe;
      logic           scl_o;
      logic           sda_o;
   } st_t;

   st_t r;
   st_t n;

   line_if scl ();
   line_if sda ();

   // both lines come from outside and are synchronised first
   line_sync u_scl_sync (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .pin   (SCL_IN),
      .ln    (scl)
   );

   line_sync u_sda_sync (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .pin   (SDA_IN),
      .ln    (sda)
   );

   // line drive {scl_low, sda_low} for each sequence phase
   function automatic logic [1:0] drv(mseq_t s, logic [1:0] p,
                                      logic av);
      logic [1:0] d;
      d = 2'b11;
      case (s)
         M_START: begin
            d = (p == 2'd0) ? 2'b01 : 2'b11;
         end
         M_RSTART: begin
            case (p)
               2'd0:    d = 2'b10;
               2'd1:    d = 2'b00;
               2'd2:    d = 2'b01;
               default: d = 2'b11;
            endcase
         end
         M_STOP: begin
            case (p)
               2'd0:    d = 2'b11;
               2'd1:    d = 2'b01;
               default: d = 2'b00;
            endcase
         end
         M_RECV: begin
            d = (p == 2'd0) ? 2'b10 : 2'b00;
         end
         M_ACK: begin
            // a one sends a not-acknowledge: the data line is released
            case (p)
               2'd0:    d = {1'b1, ~av};
               2'd1:    d = {1'b0, ~av};
               2'd2:    d = {1'b1, ~av};
               default: d = 2'b10;
            endcase
         end
         default: d = 2'b11;
      endcase
      return d;
   endfunction

   // final phase of each sequence
   function automatic logic [1:0] last_ph(mseq_t s);
      logic [1:0] p;
      p = 2'd1;
      case (s)
         M_RSTART: p = 2'd3;
         M_STOP:   p = 2'd2;
         M_ACK:    p = 2'd3;
         default:  p = 2'd1;
      endcase
      return p;
   endfunction

   // control bit that requested each sequence
   function automatic int req_bit(mseq_t s);
      int b;
      b = B_START;
      case (s)
         M_RSTART: b = B_RSTART;
         M_STOP:   b = B_STOP;
         M_RECV:   b = B_RECV;
         M_ACK:    b = B_ACKREQ;
         default:  b = B_START;
      endcase
      return b;
   endfunction

   always_comb begin
      logic [NEV-1:0] ev;
      logic [1:0]     d;
      logic [DW-1:0]  stv;
      mseq_t          pick;
      logic           on;
      logic           fin;
      ev   = '0;
      d    = 2'b00;
      stv  = '0;
      pick = M_IDLE;
      on   = r.ctrl[B_ON];
      fin  = 1'b0;
      n       = r;
      n.rdata = '0;

      // master: take the lowest-numbered request bit when idle
      case (r.ms)
         M_IDLE: begin
            if (r.ctrl[B_START]) begin
               pick = M_START;
            end else if (r.ctrl[B_RSTART]) begin
               pick = M_RSTART;
            end else if (r.ctrl[B_STOP]) begin
               pick = M_STOP;
            end else if (r.ctrl[B_RECV]) begin
               pick = M_RECV;
            end else if (r.ctrl[B_ACKREQ]) begin
               pick = M_ACK;
            end
            if (on && pick != M_IDLE) begin
               n.ms   = pick;
               n.ph   = 2'd0;
               n.mbit = '0;
               n.tmr  = TW'(HALF);
               {n.m_scl_lo, n.m_sda_lo} =
                  drv(pick, 2'd0, r.ctrl[B_ACKVAL]);
            end
         end
         default: begin
            d = drv(r.ms, r.ph, r.ctrl[B_ACKVAL]);
            if (r.tmr != '0) begin
               // a released clock held low by a slave stalls the timer
               if (d[1] || scl.lvl) begin
                  n.tmr = r.tmr - 1'b1;
               end
            end else if (r.ms == M_RECV && r.ph == 2'd1) begin
               n.msh = {r.msh[6:0], sda.lvl};
               if (r.mbit == 3'(BYTE_BITS - 1)) begin
                  fin        = 1'b1;
                  n.rxd      = {r.msh[6:0], sda.lvl};
                  n.m_scl_lo = 1'b1;
                  ev[E_MRX]  = 1'b1;
               end else begin
                  n.mbit = r.mbit + 3'd1;
                  n.ph   = 2'd0;
                  n.tmr  = TW'(HALF);
                  {n.m_scl_lo, n.m_sda_lo} = drv(r.ms, 2'd0, 1'b0);
               end
            end else if (r.ph == last_ph(r.ms)) begin
               fin = 1'b1;
            end else begin
               n.ph  = r.ph + 2'd1;
               n.tmr = TW'(HALF);
               {n.m_scl_lo, n.m_sda_lo} =
                  drv(r.ms, r.ph + 2'd1, r.ctrl[B_ACKVAL]);
            end
            if (fin) begin
               n.ctrl[req_bit(r.ms)] = 1'b0;
               n.ms        = M_IDLE;
               ev[E_MDONE] = 1'b1;
            end
         end
      endcase

      // slave: shift bytes after a start seen on the bus
      case (r.ss)
         S_IDLE: begin
            n.ss = S_IDLE;
         end
         S_BITS: begin
            if (scl.rise) begin
               n.ssh  = {r.ssh[6:0], sda.lvl};
               n.sbit = r.sbit + 4'd1;
            end
            if (scl.fall && r.sbit == 4'(BYTE_BITS)) begin
               if (r.s_gc) begin
                  n.rxd      = r.ssh;
                  ev[E_SRX]  = 1'b1;
                  n.s_sda_lo = 1'b1;
                  n.ss       = S_ACK;
               end else if (r.ssh == GC_ADDR && r.ctrl[B_GCALL]) begin
                  ev[E_GCALL] = 1'b1;
                  n.s_gc      = 1'b1;
                  n.s_sda_lo  = 1'b1;
                  n.ss        = S_ACK;
               end else begin
                  // not ours, stay off the bus
                  n.ss = S_SKIP;
               end
            end else if (scl.fall && r.ctrl[B_HOLD_EN] &&
                         !r.ctrl[B_RELEASE]) begin
               n.s_scl_lo = 1'b1;
               n.ss       = S_HOLD;
            end
         end
         S_ACK: begin
            if (scl.fall) begin
               n.s_sda_lo = 1'b0;
               n.sbit     = '0;
               if (r.ctrl[B_HOLD_EN]) begin
                  n.s_scl_lo        = 1'b1;
                  n.ctrl[B_RELEASE] = 1'b0;
                  n.ss              = S_HOLD;
               end else begin
                  n.ss = S_BITS;
               end
            end
         end
         S_HOLD: begin
            if (r.ctrl[B_RELEASE] || !r.ctrl[B_HOLD_EN]) begin
               n.s_scl_lo = 1'b0;
               n.ss       = S_BITS;
            end
         end
         S_SKIP: begin
            n.ss = S_SKIP;
         end
         default: begin
            n.ss = S_IDLE;
         end
      endcase

      // start and stop on the bus override the slave state
      if (sda.fall && scl.lvl && on) begin
         n.ss       = S_BITS;
         n.sbit     = '0;
         n.s_gc     = 1'b0;
         n.s_sda_lo = 1'b0;
         n.s_scl_lo = 1'b0;
      end else if (sda.rise && scl.lvl) begin
         n.ss       = S_IDLE;
         n.s_sda_lo = 1'b0;
         n.s_scl_lo = 1'b0;
      end

      // module off: abandon everything and let the lines go
      if (!on) begin
         n.ms       = M_IDLE;
         n.ss       = S_IDLE;
         n.m_scl_lo = 1'b0;
         n.m_sda_lo = 1'b0;
         n.s_scl_lo = 1'b0;
         n.s_sda_lo = 1'b0;
      end

      // write-one-to-clear flags; a new event wins over the clear
      n.flag = r.flag;
      if (WR && ADDR == FLAG_ADDR) begin
         n.flag = r.flag & ~WDATA[NEV-1:0];
      end
      n.flag = n.flag | ev;

      // software write lands after hardware clears, so it wins
      if (WR) begin
         case (ADDR)
            CTRL_ADDR: n.ctrl = WDATA[CW-1:0] & CTRL_WMASK;
            MASK_ADDR: n.mask = WDATA[NEV-1:0];
            default:   n.mask = n.mask;
         endcase
      end

      stv[ST_MBUSY] = (r.ms != M_IDLE);
      stv[ST_SBUSY] = (r.ss != S_IDLE);
      stv[ST_HOLD]  = r.s_scl_lo;
      stv[ST_SCL]   = scl.lvl;
      stv[ST_SDA]   = sda.lvl;

      // read data stands only in the cycle after the strobe
      if (RD) begin
         case (ADDR)
            CTRL_ADDR: n.rdata = DW'(r.ctrl);
            STAT_ADDR: n.rdata = stv;
            FLAG_ADDR: n.rdata = DW'(r.flag);
            MASK_ADDR: n.rdata = DW'(r.mask);
            RXD_ADDR:  n.rdata = DW'(r.rxd);
            default:   n.rdata = '0;
         endcase
      end

      n.irq    = |(n.flag & n.mask);
      n.scl_oe = n.m_scl_lo | n.s_scl_lo;
      n.sda_oe = n.m_sda_lo | n.s_sda_lo;
      n.scl_o  = 1'b0;
      n.sda_o  = 1'b0;
   end

   // single state register
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         r      <= '0;
         r.ctrl <= CTRL_RST;
      end else begin
         r <= n;
      end
   end

   assign RDATA   = r.rdata;
   assign IRQ     = r.irq;
   assign SCL_OUT = r.scl_o;
   assign SCL_OE  = r.scl_oe;
   assign SDA_OUT = r.sda_o;
   assign SDA_OE  = r.sda_oe;
endmodule

//--- i2cseq_pkg.sv
// shared constants and types of the bus sequence controller
package i2cseq_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   // register byte addresses
   localparam logic [AW-1:0] CTRL_ADDR = 8'h00;
   localparam logic [AW-1:0] STAT_ADDR = 8'h04;
   localparam logic [AW-1:0] FLAG_ADDR = 8'h08;
   localparam logic [AW-1:0] MASK_ADDR = 8'h0c;
   localparam logic [AW-1:0] RXD_ADDR  = 8'h10;
   // control register fields
   localparam int CW        = 16;
   localparam int B_START   = 0;
   localparam int B_RSTART  = 1;
   localparam int B_STOP    = 2;
   localparam int B_RECV    = 3;
   localparam int B_ACKREQ  = 4;
   localparam int B_ACKVAL  = 5;
   localparam int B_HOLD_EN = 6;
   localparam int B_GCALL   = 7;
   localparam int B_RELEASE = 12;
   localparam int B_ON      = 15;
   localparam logic [CW-1:0] CTRL_RST   = 16'h1000;
   localparam logic [CW-1:0] CTRL_WMASK = 16'h90ff;
   // event flags
   localparam int NEV     = 4;
   localparam int E_MDONE = 0;
   localparam int E_GCALL = 1;
   localparam int E_SRX   = 2;
   localparam int E_MRX   = 3;
   // status register fields
   localparam int ST_MBUSY = 0;
   localparam int ST_SBUSY = 1;
   localparam int ST_HOLD  = 2;
   localparam int ST_SCL   = 3;
   localparam int ST_SDA   = 4;
   // bus timing: half bit period, a least time
   localparam int CLK_NS   = 100;
   localparam int HALF_NS  = 5000;
   localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam int BYTE_BITS = 8;
   typedef enum logic [2:0] {
      M_IDLE, M_START, M_RSTART, M_STOP, M_RECV, M_ACK
   } mseq_t;
   typedef enum logic [2:0] {
      S_IDLE, S_BITS, S_ACK, S_HOLD, S_SKIP
   } sslv_t;
endpackage

//--- line_if.sv
// synchronised level and edges of one bus line
`timescale 1ns/10ps
interface line_if;
   logic lvl;
   logic rise;
   logic fall;
   modport src (output lvl, rise, fall);
   modport snk (input lvl, rise, fall);
endinterface

//--- line_sync.sv
// two-flop synchroniser with edge detection for one bus line
`timescale 1ns/10ps
module line_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   line_if.src      ln
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } sync_t;

   sync_t r;
   sync_t n;

   // s1 feeds only s2; edges are found on s2 against its delayed copy
   always_comb begin
      n      = r;
      n.s1   = pin;
      n.s2   = r.s1;
      n.prev = r.s2;
   end

   // lines idle high, so reset to one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '1;
      end else begin
         r <= n;
      end
   end

   assign ln.lvl  = r.s2;
   assign ln.rise = r.s2 & ~r.prev;
   assign ln.fall = ~r.s2 & r.prev;
endmodule

//--- i2cseq_monitor.sv
// port assertions for the bus sequence controller
`timescale 1ns/10ps
module i2cseq_monitor
   import i2cseq_pkg::*;
#(
   parameter int HALF = 50
) (
   input wire logic                      CLK_SYS,
   input wire logic                      RST_N,
   input wire logic [i2cseq_pkg::AW-1:0] ADDR,
   input wire logic [i2cseq_pkg::DW-1:0] WDATA,
   input wire logic                      WR,
   input wire logic                      RD,
   input wire logic [i2cseq_pkg::DW-1:0] RDATA,
   input wire logic                      SCL_IN,
   input wire logic                      SCL_OUT,
   input wire logic                      SCL_OE,
   input wire logic                      SDA_IN,
   input wire logic                      SDA_OUT,
   input wire logic                      SDA_OE,
   input wire logic                      IRQ
);
   // one phase is HALF+1 cycles; slack covers synchroniser lag
   localparam int LO = HALF;
   localparam int HI = HALF + 4;
   default clocking mon_cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // data pulled while clock is high: start of a start condition
   sequence s_data_first;
      $rose(SDA_OE) && !SCL_OE && SCL_IN;
   endsequence
   sequence s_clock_next;
      SDA_OE throughout (##[LO:HI] $rose(SCL_OE));
   endsequence
   // data released while clock is high: a stop
   sequence s_data_free;
      $fell(SDA_OE) && !SCL_OE && SCL_IN;
   endsequence
   AST_START_ORDER: assert property (s_data_first |-> s_clock_next)
      else $error("clock not pulled one phase after data");
   AST_STOP_IDLE: assert property (
      s_data_free |=> (!SDA_OE && !SCL_OE)[*8])
      else $error("lines driven right after stop");
   AST_SLAVE_ACK: assert property (
      $rose(SDA_OE) && !SCL_OE && !SCL_IN |=> SDA_OE[*4])
      else $error("slave acknowledge dropped early");
   AST_OFF_QUIET: assert property (
      WR && ADDR == CTRL_ADDR && !WDATA[B_ON] |=> ##1 !SCL_OE && !SDA_OE)
      else $error("lines driven with block off");
   AST_IRQ_MASKED: assert property (
      WR && ADDR == MASK_ADDR && WDATA[NEV-1:0] == '0 ##1 !WR |=> !IRQ)
      else $error("interrupt with all events masked");
   AST_IRQ_STICKY: assert property (IRQ && !WR && !$past(WR) |=> IRQ)
      else $error("interrupt dropped without a write");
   // read data only after a read
   AST_RDATA_IDLE: assert property (!RD |=> RDATA == '0)
      else $error("read data without read");
   AST_UNMAPPED: assert property (RD && ADDR > RXD_ADDR |=> RDATA == '0)
      else $error("unmapped read not zero");
   AST_CTRL_RSVD: assert property (RD && ADDR == CTRL_ADDR
      |=> (RDATA & 32'hffff_6f00) == '0)
      else $error("reserved control bits read one");
   // open drain: only the enables move
   AST_OPEN_DRAIN: assert property (!SCL_OUT && !SDA_OUT)
      else $error("line output value not low");
endmodule
bind i2c_bus_sequence_control i2cseq_monitor #(.HALF(HALF)) u_mon (.*);

//--- i2c_peer_model.sv
// bus peer: slave byte sender and general call master
`timescale 1ns/10ps
module i2c_peer_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       arm,
   input  wire logic [7:0] tx,
   input  wire logic       go,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic            busy,
   output logic            nack
);
   int   idx   = 8;
   logic m_sda = 0;
   initial begin
      scl_oe = 0;
      busy = 0;
      nack = 1;
   end
   // a released line floats up through the bus pull-up
   assign sda_oe = m_sda | (idx < 8 && !tx[7-idx]);
   // slave send: next bit after each clock fall, msb first
   always @(posedge arm) idx = 0;
   always @(negedge scl) if (idx < 8) idx = idx + 1;
   // master: start, address from tx, ack clock, stop; 800 ns bits
   always @(posedge go) begin
      busy = 1;
      m_sda = 1;
      #400;
      for (int i = 0; i < 9; i++) begin
         scl_oe = 1;
         #200;
         m_sda = (i < 8) && !tx[7-i];
         #200;
         scl_oe = 0;
         // honours a slave that stretches the clock
         wait (scl);
         #400;
         if (i == 8)
            nack = sda;
      end
      scl_oe = 1;
      m_sda = 1;
      #400;
      scl_oe = 0;
      wait (scl);
      #400;
      m_sda = 0;
      #400;
      busy = 0;
   end
endmodule

//--- i2c_bus_sequence_control_tb_top.sv
// self-checking bench of the bus sequence controller
`timescale 1ns/10ps
module i2c_bus_sequence_control_tb_top;
   import i2cseq_pkg::*;
   logic          clk = 0;
   logic          rst_n = 0;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdata = '0;
   logic          wr = 0;
   logic          rd = 0;
   logic          arm = 0;
   logic          go = 0;
   logic [7:0]    tx = 8'h00;
   logic [DW-1:0] rdata;
   logic [DW-1:0] v;
   logic          scl_oe, sda_oe, p_scl, p_sda, busy, nack, irq;
   int            n_mismatch = 0;
   int            checks = 0;
   int            cyc = 0;
   // open drain bus with pull-ups
   wire           scl = !(scl_oe | p_scl);
   wire           sda = !(sda_oe | p_sda);
   i2c_bus_sequence_control #(.HALF(4)) u_dut (
      .CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .SCL_IN(scl), .SCL_OUT(),
      .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
      .IRQ(irq)
   );
   i2c_peer_model u_peer (
      .scl(scl), .sda(sda), .arm(arm), .tx(tx), .go(go),
      .scl_oe(p_scl), .sda_oe(p_sda), .busy(busy), .nack(nack)
   );
   initial forever #50 clk = ~clk;
   // hang guard, far above the expected run of well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(string nm, logic [DW-1:0] e, logic [DW-1:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(logic [AW-1:0] a, logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(logic [AW-1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1;
      v = rdata;
   endtask
   // poll control until hardware clears a request bit
   task automatic wait_clr(int b);
      int n;
      n = 0;
      do begin
         rd_reg(CTRL_ADDR);
         n++;
      end while (v[b] !== 1'b0 && n < 500);
      // a request that never clears counts against the run
      chk("req_clear", 0, v[b]);
   endtask
   task automatic go_peer();
      @(posedge clk);
      go <= 1;
      @(posedge clk);
      go <= 0;
   endtask
   task automatic wait_peer();
      int n;
      n = 0;
      while (busy === 1'b1 && n < 999) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("peer_idle", 0, busy);
   endtask
   // wait for the clock line enable to reach a level, bounded
   task automatic wait_oe(logic e);
      int n;
      n = 0;
      while (scl_oe !== e && n < 999) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("scl_oe_wait", e, scl_oe);
   endtask
   task automatic t_regs();
      rd_reg(CTRL_ADDR);
      chk("ctrl", 32'h0000_1000, v);
      rd_reg(MASK_ADDR);
      chk("mask", 0, v);
      rd_reg(8'h14);
      chk("unmapped", 0, v);
      wr_reg(CTRL_ADDR, 32'hffff_6f00);
      rd_reg(CTRL_ADDR);
      // reserved bits dropped; release and on written as zero
      chk("reserved", 32'h0000_0000, v);
   endtask
   // general call ignored, then flagged and acknowledged
   task automatic t_gcall();
      for (int g = 0; g < 2; g++) begin
         wr_reg(CTRL_ADDR, 32'h0000_8000 | (g << B_GCALL));
         go_peer();
         wait_peer();
         rd_reg(FLAG_ADDR);
         chk("gc_flag", g << E_GCALL, v);
         chk("gc_nack", !g, nack);
         wr_reg(FLAG_ADDR, 32'h0000_000f);
      end
   endtask
   // slave holds the clock at the first fall after the start and again after the ack, until software releases it
   task automatic t_hold();
      wr_reg(CTRL_ADDR, 32'h0000_80c0);
      go_peer();
      wait_oe(1'b1);
      repeat (20) @(posedge clk);
      rd_reg(CTRL_ADDR);
      chk("held", 1, scl_oe);
      chk("release", 0, v[B_RELEASE]);
      rd_reg(STAT_ADDR);
      chk("stat_hold", 1, v[ST_HOLD]);
      wr_reg(CTRL_ADDR, 32'h0000_90c0);
      // a receive stretch follows the acknowledge and clears release
      wait_oe(1'b0);
      wait_oe(1'b1);
      rd_reg(CTRL_ADDR);
      chk("ack_release", 0, v[B_RELEASE]);
      wr_reg(CTRL_ADDR, 32'h0000_90c0);
      wait_peer();
      chk("freed", 0, scl_oe);
      wr_reg(CTRL_ADDR, 32'h0000_8000);
      wr_reg(FLAG_ADDR, 32'h0000_000f);
   endtask
   task automatic t_seq(int b, logic [1:0] e);
      wr_reg(CTRL_ADDR, 32'h0000_8000 | (1 << b));
      wait_clr(b);
      chk("seq_lines", e, {scl_oe, sda_oe});
      rd_reg(FLAG_ADDR);
      chk("seq_done", 1, v[E_MDONE]);
      wr_reg(FLAG_ADDR, 32'h0000_000f);
   endtask
   task automatic t_recv();
      @(posedge clk);
      tx <= 8'h5a;
      arm <= 1;
      @(posedge clk);
      arm <= 0;
      wr_reg(CTRL_ADDR, 32'h0000_8008);
      wait_clr(B_RECV);
      chk("rx_held", 1, scl_oe);
      rd_reg(RXD_ADDR);
      chk("rx_byte", 32'h0000_005a, v);
      rd_reg(FLAG_ADDR);
      chk("rx_flag", 1, v[E_MRX]);
      wr_reg(FLAG_ADDR, 32'h0000_000f);
   endtask
   // both ack values; data level while the clock is high
   task automatic t_ack();
      for (int a = 0; a < 2; a++) begin
         wr_reg(CTRL_ADDR, 32'h0000_8010 | (a << B_ACKVAL));
         // clock released: second phase of the sequence
         wait_oe(1'b0);
         chk("ack_bit", !a, sda_oe);
         wait_clr(B_ACKREQ);
         chk("ack_end", 2'b10, {scl_oe, sda_oe});
      end
   endtask
   // repeated start masked, then unmasked, then cleared
   task automatic t_irq();
      wr_reg(FLAG_ADDR, 32'h0000_000f);
      wr_reg(CTRL_ADDR, 32'h0000_8002);
      wait_clr(B_RSTART);
      chk("rs_lines", 2'b11, {scl_oe, sda_oe});
      chk("irq_off", 0, irq);
      wr_reg(MASK_ADDR, 32'h0000_000f);
      @(posedge clk);
      #1;
      chk("irq_on", 1, irq);
      // an all-zero mask hides the pending event
      wr_reg(MASK_ADDR, 32'h0000_0000);
      #1;
      chk("irq_mask", 0, irq);
      wr_reg(MASK_ADDR, 32'h0000_000f);
      wr_reg(FLAG_ADDR, 32'h0000_0001);
      @(posedge clk);
      #1;
      chk("irq_clr", 0, irq);
   endtask
   // one master request at a time, each waited out
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_gcall();
      t_hold();
      t_seq(B_START, 2'b11);
      t_recv();
      t_ack();
      t_irq();
      t_seq(B_STOP, 2'b00);
      chk("bus_free", 2'b11, {scl, sda});
      report_and_stop();
   end
endmodule
